// >>> hdl/gpmux_pkg.sv
// Purpose: Constants and state type of the pin function multiplexer.
// Assumes: Two ports of eight pins; pin index = port * 8 + pin.
// Notes: Lower flat index means lower port letter, then lower pin.
//
// How it works
// - Each pin carries at most one function.
// - Duplicate signal: lower port letter wins.
// - Read returns live pin level, any direction.
// - Unmasked bits read back as zero.
// - Bit n of mask/data is pin n.
// - Protected pins resist ordinary configuration writes.
// - Pad settings never route any signal.
package gpmux_pkg;
  localparam int NPORT = 2;
  localparam int PPIN = 8;
  localparam int NPIN = NPORT * PPIN;
  localparam int FW = 3;
  localparam int NF = 8;
  // Function codes carried in the low bits of pin_function_select_value
  localparam logic [FW-1:0] FUNC_GPIO = 3'h0;
  localparam logic [FW-1:0] FUNC_DEBUG = 3'h7;
  // Debug pins on port A 0..3, interrupt-capable pin on port B 7
  localparam logic [NPIN-1:0] PROT_MASK = 16'h800F;
  // Guard key value is arbitrary
  localparam logic [31:0] GUARD_KEY = 32'h5A5A00C3;
  localparam logic [1:0] OP_SEL = 2'h0;
  localparam logic [1:0] OP_DIR = 2'h1;
  localparam logic [1:0] OP_GUARD = 2'h2;
  localparam logic [1:0] OP_COMMIT = 2'h3;

  typedef struct packed {
    logic [NPIN-1:0][FW-1:0] sel;
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] commit;
    logic unlocked;
    logic [NPIN-1:0] pad_out;
    logic [NPIN-1:0] pad_oe;
    logic [NF-1:0] periph_in;
    logic [PPIN-1:0] rd_data;
    logic rd_valid;
  } gpmux_st_t;

  function automatic gpmux_st_t gpmux_rst_state();
    gpmux_st_t s;
    s = '0;
    for (int i = 0; i < NPIN; i++) begin
      s.sel[i] = PROT_MASK[i] ? FUNC_DEBUG : FUNC_GPIO;
    end
    return s;
  endfunction
endpackage

// >>> hdl/gpmux_top.sv
// Purpose: Per-pin function multiplexer with masked pin-state readback.
// Assumes: Commands and pad inputs are synchronous to ref_clk.
// Notes: Outputs lag pad, data and read inputs by one clock and configuration commands by two; no software bus.
`timescale 1ns/1ps
module gpmux_top
  import gpmux_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Configuration command
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_port,
  input wire logic [PPIN-1:0] pin_select_mask,
  input wire logic [31:0] pin_function_select_value,
  // Pin-state read
  input wire logic rd_req,
  input wire logic rd_port,
  input wire logic [PPIN-1:0] rd_mask,
  output logic [PPIN-1:0] rd_data,
  output logic rd_valid,
  // Peripheral side, indexed by function code
  input wire logic [NF-1:0] periph_out,
  input wire logic [NF-1:0] periph_oe,
  output logic [NF-1:0] periph_in,
  // Plain GPIO data
  input wire logic [NPIN-1:0] gpio_dout,
  // Package pins
  input wire logic [NPIN-1:0] pad_in,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe
);
  localparam gpmux_st_t ST_RST = gpmux_rst_state();

  gpmux_st_t st_r;
  gpmux_st_t st_nxt;
  logic [NF-1:0] taken;
  logic [NPIN-1:0] owns;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    int idx;
    idx = 0;
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    taken = '0;
    owns = '0;
    // First claimant in index order owns a signal; later ones stay idle
    for (int i = 0; i < NPIN; i++) begin
      if (st_r.sel[i] != FUNC_GPIO && !taken[st_r.sel[i]]) begin
        owns[i] = 1'b1;
        taken[st_r.sel[i]] = 1'b1;
      end
    end
    st_nxt.periph_in = '0;
    for (int i = 0; i < NPIN; i++) begin
      if (owns[i]) begin
        st_nxt.periph_in[st_r.sel[i]] = pad_in[i];
      end
      // Only the select steers the pin; direction serves GPIO alone
      if (st_r.sel[i] == FUNC_GPIO) begin
        st_nxt.pad_out[i] = gpio_dout[i];
        st_nxt.pad_oe[i] = st_r.dir[i];
      end else if (owns[i]) begin
        st_nxt.pad_out[i] = periph_out[st_r.sel[i]];
        st_nxt.pad_oe[i] = periph_oe[st_r.sel[i]];
      end else begin
        st_nxt.pad_out[i] = 1'b0;
        st_nxt.pad_oe[i] = 1'b0;
      end
    end
    if (cmd_valid) begin
      unique case (cmd_op)
        OP_SEL: begin
          for (int p = 0; p < PPIN; p++) begin
            idx = int'(cmd_port) * PPIN + p;
            if (pin_select_mask[p] && (!PROT_MASK[idx] || st_r.commit[idx])) begin
              st_nxt.sel[idx] = pin_function_select_value[FW-1:0];
            end
          end
        end
        OP_DIR: begin
          for (int p = 0; p < PPIN; p++) begin
            idx = int'(cmd_port) * PPIN + p;
            if (pin_select_mask[p] && (!PROT_MASK[idx] || st_r.commit[idx])) begin
              st_nxt.dir[idx] = pin_function_select_value[0];
            end
          end
        end
        OP_GUARD: begin
          st_nxt.unlocked = (pin_function_select_value == GUARD_KEY);
        end
        OP_COMMIT: begin
          // Ignored unless the guard key came first
          if (st_r.unlocked) begin
            st_nxt.commit[cmd_port*PPIN +: PPIN] = pin_select_mask;
          end
        end
      endcase
    end
    if (rd_req) begin
      st_nxt.rd_data = pad_in[rd_port*PPIN +: PPIN] & rd_mask;
      st_nxt.rd_valid = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Straight from the state flops, so no glitch reaches a pin
  assign rd_data = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;
  assign periph_in = st_r.periph_in;
  assign pad_out = st_r.pad_out;
  assign pad_oe = st_r.pad_oe;

  // ****************************************
  // Checks
  // ****************************************
  // Helper flops for the checks only; they never reach an output
  logic seen_r;
  logic [NPIN-1:0] dup_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seen_r <= 1'b0;
      dup_r <= '0;
    end else begin
      seen_r <= 1'b1;
      for (int i = 0; i < NPIN; i++) begin
        dup_r[i] <= (st_r.sel[i] != FUNC_GPIO) && !owns[i];
      end
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence read_issued;
    rd_req;
  endsequence
  sequence read_done;
    ##1 rd_valid;
  endsequence

  // Guard, commit and locked-direction commands, one command each
  sequence guard_match;
    cmd_valid && cmd_op == OP_GUARD && pin_function_select_value == GUARD_KEY;
  endsequence
  sequence guard_miss;
    cmd_valid && cmd_op == OP_GUARD && pin_function_select_value != GUARD_KEY;
  endsequence
  sequence commit_low;
    cmd_valid && cmd_op == OP_COMMIT && !cmd_port && st_r.unlocked;
  endsequence
  sequence dir_locked;
    cmd_valid && cmd_op == OP_DIR && !cmd_port && pin_select_mask[0] && !st_r.commit[0];
  endsequence

  reset_select_a: assert property (!seen_r |-> st_r.sel == ST_RST.sel)
    else $error("select not at reset value");
  read_level_a: assert property (read_issued |-> read_done ##0
    rd_data == ($past(pad_in[rd_port*PPIN +: PPIN]) & $past(rd_mask)))
    else $error("read data not the pin level");
  read_mask_a: assert property (rd_valid |-> (rd_data & ~$past(rd_mask)) == '0)
    else $error("unselected read bit not zero");
  read_bit0_a: assert property (rd_req && rd_mask[0] && !rd_port |=> rd_data[0] == $past(pad_in[0]))
    else $error("bit 0 not mapped to pin 0");
  dup_idle_a: assert property (|dup_r |-> (pad_oe & dup_r) == '0)
    else $error("losing duplicate pin drives");
  one_source_a: assert property (owns[4] && seen_r
    |=> pad_out[4] == $past(periph_out[st_r.sel[4]]))
    else $error("pin not driven by its one function");
  protect_pin_a: assert property (cmd_valid && cmd_op == OP_SEL && !cmd_port && pin_select_mask[0]
    && !st_r.commit[0] |=> $stable(st_r.sel[0]))
    else $error("protected pin changed while locked");
  pad_no_route_a: assert property (cmd_valid && cmd_op == OP_DIR |=> $stable(st_r.sel))
    else $error("pad write changed routing");
  commit_locked_a: assert property (cmd_valid && cmd_op == OP_COMMIT && !st_r.unlocked
    |=> $stable(st_r.commit))
    else $error("commit taken while locked");

  guard_open_a: assert property (guard_match |=> st_r.unlocked)
    else $error("guard key did not unlock");
  guard_relock_a: assert property (guard_miss |=> !st_r.unlocked)
    else $error("wrong guard value left pins unlocked");
  guard_hold_a: assert property (!(cmd_valid && cmd_op == OP_GUARD) |=> $stable(st_r.unlocked))
    else $error("unlock changed without a guard write");
  commit_take_a: assert property (commit_low |=> st_r.commit[PPIN-1:0] == $past(pin_select_mask))
    else $error("commit mask not taken after unlock");
  dir_protect_a: assert property (dir_locked |=> $stable(st_r.dir[0]))
    else $error("protected pin direction changed while locked");
  read_pulse_a: assert property (rd_valid |-> $past(rd_req))
    else $error("read answer without a request");
  read_answer_a: assert property (!rd_req |=> !rd_valid)
    else $error("read answer stood too long");
  read_bit_b_a: assert property (rd_req && rd_mask[3] && rd_port |=> rd_data[3] == $past(pad_in[PPIN+3]))
    else $error("port B bit not mapped to its pin");
  gpio_path_a: assert property (st_r.sel[5] == FUNC_GPIO
    |=> pad_out[5] == $past(gpio_dout[5]) && pad_oe[5] == $past(st_r.dir[5]))
    else $error("plain pin not driven from its data and direction");
  dup_quiet_a: assert property (|dup_r |-> (pad_out & dup_r) == '0)
    else $error("losing duplicate pin shows data");
  unowned_in_a: assert property (seen_r |-> (periph_in & ~$past(taken)) == '0)
    else $error("function input without an owning pin");
  owner_input_a: assert property (owns[4] |=> periph_in[$past(st_r.sel[4])] == $past(pad_in[4]))
    else $error("function input not from its owning pin");
endmodule

// >>> test/gpmux_partner.sv
// Purpose: Pad model standing on the package side of the mux.
// Assumes: A driven pin reads back its own drive level.
// Notes: Undriven pins show the board level set by the bench.
`timescale 1ns/1ps
module gpmux_partner
  import gpmux_pkg::*;
(
  // Pins
  input wire logic [NPIN-1:0] pad_out,
  input wire logic [NPIN-1:0] pad_oe,
  input wire logic [NPIN-1:0] board_lvl,
  output logic [NPIN-1:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_lvl);
endmodule

// >>> test/gpmux_top_tb.sv
// Purpose: Self-checking bench for the pin function mux.
// Assumes: Inputs change on the falling edge of ref_clk.
// Notes: GPIO output data drives pin 5 high once it is an output.
`timescale 1ns/1ps
module gpmux_top_tb;
  import gpmux_pkg::*;
  logic ref_clk = 0;
  logic resetn = 0;
  logic cmd_valid = 0;
  logic cmd_port = 0;
  logic rd_req = 0;
  logic rd_port = 0;
  logic rd_valid;
  logic [1:0] cmd_op = 0;
  logic [7:0] pin_select_mask = 0;
  logic [7:0] rd_mask = 0;
  logic [7:0] rd_data;
  logic [31:0] pin_function_select_value = 0;
  logic [NF-1:0] periph_out = 0;
  logic [NF-1:0] periph_oe = 0;
  logic [NF-1:0] periph_in;
  logic [NPIN-1:0] pad_in, pad_out, pad_oe;
  logic [NPIN-1:0] board_lvl = 16'h5AFF;
  logic [NPIN-1:0] gpio_dout = 16'h0000;
  int err_total = 0;
  int num_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  gpmux_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_port(cmd_port), .pin_select_mask(pin_select_mask), .pin_function_select_value(pin_function_select_value),
    .rd_req(rd_req), .rd_port(rd_port), .rd_mask(rd_mask), .rd_data(rd_data), .rd_valid(rd_valid),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .gpio_dout(gpio_dout),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  gpmux_partner u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .board_lvl(board_lvl), .pad_in(pad_in));

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Command, then two edges for the pads to follow
  task automatic cmd(input logic [1:0] op, input logic prt, input logic [7:0] m, input logic [31:0] v);
    @(negedge ref_clk);
    {cmd_valid, cmd_op, cmd_port, pin_select_mask, pin_function_select_value} = {1'b1, op, prt, m, v};
    @(negedge ref_clk);
    cmd_valid = 0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic rd(input logic prt, input logic [7:0] m, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge ref_clk);
    {rd_req, rd_port, rd_mask} = {1'b1, prt, m};
    @(negedge ref_clk);
    rd_req = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    if (rd_valid !== 1'b1) begin
      err_total++;
      results();
    end else begin
      chk("rd_data", {8'h00, rd_data}, {8'h00, exp});
      @(negedge ref_clk);
      chk("rd_valid", {15'h0, rd_valid}, 16'h0000);
    end
  endtask

  task automatic t_reset();
    repeat (2) @(negedge ref_clk);
    chk("pad_oe", pad_oe, 16'h0000);
    {periph_oe, periph_out} = {8'h80, 8'h80};
    repeat (2) @(negedge ref_clk);
    chk("pad_oe", pad_oe, 16'h0001);
    chk("pad_out", pad_out, 16'h0001);
  endtask

  task automatic t_route();
    {periph_oe, periph_out} = {8'h08, 8'h08};
    gpio_dout = 16'h0020;
    cmd(OP_SEL, 1'b0, 8'h10, 32'h3);
    chk("pad_oe", pad_oe, 16'h0010);
    cmd(OP_DIR, 1'b0, 8'h20, 32'h1);
    chk("pad_out", pad_out, 16'h0030);
    chk("pad_oe", pad_oe, 16'h0030);
  endtask

  task automatic t_dup();
    periph_out = 8'h00;
    cmd(OP_SEL, 1'b1, 8'h10, 32'h3);
    chk("pad_oe", pad_oe, 16'h0030);
    chk("periph_in", {8'h00, periph_in}, 16'h0080);
  endtask

  task automatic t_prot();
    {periph_oe, periph_out} = {8'h2C, 8'h04};
    cmd(OP_DIR, 1'b0, 8'h01, 32'h1);
    cmd(OP_SEL, 1'b0, 8'h01, 32'h2);
    chk("pad_oe", pad_oe, 16'h0030);
    cmd(OP_GUARD, 1'b0, 8'h00, GUARD_KEY);
    cmd(OP_COMMIT, 1'b0, 8'h01, 32'h0);
    cmd(OP_SEL, 1'b0, 8'h01, 32'h2);
    chk("pad_oe", pad_oe, 16'h0031);
    chk("pad_out", pad_out, 16'h0021);
    cmd(OP_GUARD, 1'b0, 8'h00, 32'h0);
    cmd(OP_COMMIT, 1'b1, 8'h80, 32'h0);
    cmd(OP_SEL, 1'b1, 8'h80, 32'h5);
    chk("pad_oe", pad_oe, 16'h0031);
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    resetn = 1;
    t_reset();
    t_route();
    t_dup();
    t_prot();
    rd(1'b1, 8'h0F, 8'h0A);
    rd(1'b0, 8'hFF, 8'hEF);
    results();
  end
endmodule
